// file: sim/aesdrq_dma_model.sv
// Model of the DMA controller that watches the gated request lines
module aesdrq_dma_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Request lines from the block: ctx-in, data-in, data-out, ctx-out
    input wire logic [3:0] req,
    // Live view of the lines and transfers served
    output logic [3:0] seen,
    output int served
);
    timeunit 1ns;
    timeprecision 1ns;

    // The arbiter looks at the lines as levels
    assign seen = req;

    // One word moved for each request line high in a cycle
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            served <= 0;
        end else begin
            served <= served + $countones(req);
        end
    end
endmodule

// file: sim/tb_aes_dma_request_config.sv
// Self-checking bench of the DMA request configuration block
`include "aesdrq_map.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end

module tb_aes_dma_request_config;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk, resetn, read, write, waitrequest, irq_ff, c_in, d_in, d_out, c_out;
    logic [7:0] address;
    logic [31:0] writedata, readdata, q, wd, cfg, m;
    logic [3:0] byteenable, dma_src, irq_src, seen, ien, be;
    logic [31:0] corner [4] = '{32'h0000_0240, 32'h0000_0100, 32'hFFFF_FFFF, 32'h0000_0300};
    int n_mismatch, samples_checked, served;

    aesdrq_top DUT (.ref_clk(ref_clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .dma_src(dma_src), .irq_src(irq_src),
        .dma_req_ctx_in_ff(c_in), .dma_req_data_in_ff(d_in), .dma_req_data_out_ff(d_out),
        .dma_req_ctx_out_ff(c_out), .irq_ff(irq_ff));

    aesdrq_dma_model dma (.ref_clk(ref_clk), .resetn(resetn), .req({c_out, d_out, d_in, c_in}),
        .seen(seen), .served(served));

    // Clock of 40 ns
    always #20 ref_clk = ~ref_clk;

    // Verdict and end of run
    task end_sim;
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int i;
        @(posedge ref_clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        byteenable <= be;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (waitrequest === 1'b0) break;
        end
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (i == 50) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // Gated requests and interrupt from controls and sources
    function automatic logic [4:0] expect_out(input logic [31:0] c, input logic [3:0] e, s, i);
        logic co;
        logic ce;
        co = c[9] ? c[6] : c[8];
        ce = c[9] ? e[2] : e[3];
        return {|(i & {ce, e[2:0]}), s[3] & co, s[2] & c[6], s[1] & c[5], s[0] & c[7]};
    endfunction

    // Main sequence: reset, corner controls, then random controls and sources
    initial begin
        ref_clk = 0;
        resetn = 0;
        {read, write, address, writedata, byteenable} = '0;
        dma_src = 4'h0;
        irq_src = 4'h0;
        n_mismatch = 0;
        samples_checked = 0;
        cfg = 32'h0;
        ien = 4'h0;
        void'($urandom(88));
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        dma_src <= 4'hF;
        irq_src <= 4'hF;
        @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("outputs after reset", 5'h00, {irq_ff, seen})
        bus(1'b0, `AESDRQ_CFG_OFS, 32'h0, 4'hF);
        `CHK("config after reset", `AESDRQ_CFG_RST, q)
        `CHK("served after reset", 0, served)
        bus(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 8'h40, 32'h0, 4'hF);
        `CHK("unmapped read", 32'h0, q)
        for (int k = 0; k < 44; k++) begin
            wd = (k < 4) ? corner[k] : $urandom;
            be = (k % 4 == 3) ? 4'($urandom) : 4'hF;
            m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            bus(1'b1, `AESDRQ_CFG_OFS, wd, be);
            cfg = (cfg & ~(m & `AESDRQ_CFG_MASK)) | (wd & m & `AESDRQ_CFG_MASK);
            wd = $urandom;
            bus(1'b1, `AESDRQ_IRQEN_OFS, wd, 4'hF);
            ien = wd[3:0];
            bus(1'b0, `AESDRQ_CFG_OFS, 32'h0, 4'hF);
            `CHK("config readback", cfg, q)
            bus(1'b0, `AESDRQ_IRQEN_OFS, 32'h0, 4'hF);
            `CHK("irq enable readback", {28'h0, ien}, q)
            dma_src <= 4'($urandom);
            irq_src <= 4'($urandom);
            @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK("requests and irq", expect_out(cfg, ien, dma_src, irq_src), {irq_ff, seen})
            bus(1'b0, `AESDRQ_IRQST_OFS, 32'h0, 4'hF);
            `CHK("irq status", {28'h0, irq_src}, q)
        end
        // Reset in mid-run must clear every control that was set
        dma_src <= 4'hF;
        irq_src <= 4'hF;
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("outputs after mid reset", 5'h00, {irq_ff, seen})
        bus(1'b0, `AESDRQ_CFG_OFS, 32'h0, 4'hF);
        `CHK("config after mid reset", `AESDRQ_CFG_RST, q)
        bus(1'b0, `AESDRQ_IRQEN_OFS, 32'h0, 4'hF);
        `CHK("irq enable after mid reset", 32'h0, q)
        end_sim();
    end
endmodule

// file: verilog/aesdrq_gate.sv
// Registered enable gate for a group of request lines
module aesdrq_gate #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Sources and their enables
    input wire logic [W-1:0] src,
    input wire logic [W-1:0] en,
    // Gated lines and their combined level
    output logic [W-1:0] q_ff,
    output logic any_ff
);

    typedef struct packed {
        logic [W-1:0] q;
        logic any;
    } aesdrq_gate_t;

    aesdrq_gate_t cur_ff;
    aesdrq_gate_t nxt_cur;

    // Pass a source only while its enable is set
    always_comb begin
        nxt_cur.q = src & en;
        nxt_cur.any = |(src & en);
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign q_ff = cur_ff.q;
    assign any_ff = cur_ff.any;

endmodule

// file: verilog/aesdrq_map.svh
// Register offsets, field positions and reset values of the DMA request block
`ifndef AESDRQ_MAP_SVH
`define AESDRQ_MAP_SVH

// Byte offsets on the register bus
`define AESDRQ_CFG_OFS 8'h84
`define AESDRQ_IRQST_OFS 8'h8C
`define AESDRQ_IRQEN_OFS 8'h90

// Configuration register fields
`define AESDRQ_CFG_DIN_BIT 5
`define AESDRQ_CFG_DOUT_BIT 6
`define AESDRQ_CFG_CIN_BIT 7
`define AESDRQ_CFG_COUT_BIT 8
`define AESDRQ_CFG_MAP_BIT 9
`define AESDRQ_CFG_MASK 32'h0000_03E0

// Request and interrupt source positions (enable register layout)
`define AESDRQ_SRC_CIN 0
`define AESDRQ_SRC_DIN 1
`define AESDRQ_SRC_DOUT 2
`define AESDRQ_SRC_COUT 3
`define AESDRQ_SRC_MASK 32'h0000_000F

// Reset values
`define AESDRQ_CFG_RST 32'h0000_0000
`define AESDRQ_IRQEN_RST 4'h0
`define AESDRQ_RDATA_RST 32'h0000_0000

`endif

// file: verilog/aesdrq_pkg.sv
// Types shared by the DMA request block
package aesdrq_pkg;

    // Bus answer states, one-hot
    typedef enum logic [1:0] {
        AESDRQ_ST_IDLE = 2'b01,
        AESDRQ_ST_ACK = 2'b10
    } aesdrq_state_t;

    // Whole state of the top module
    typedef struct packed {
        aesdrq_state_t state;
        logic waitrequest;
        logic [31:0] readdata;
        logic din_en;
        logic dout_en;
        logic cin_en;
        logic cout_en;
        logic map_cout;
        logic [3:0] irq_en;
    } aesdrq_regs_t;

endpackage

// file: verilog/aesdrq_top.sv
// DMA request configuration register bank of the crypto accelerator
//
// Overview of operation
// - The data-input DMA request is passed on only while config bit 5 is set.
// - The data-output DMA request is passed on only while config bit 6 is set.
// - The context-input DMA request is passed on only while config bit 7 is set.
// - The context-output DMA request is passed on only while config bit 8 is set.
// - With config bit 9 set, context-output request and interrupt use the data-output enables.
// - Reset clears all five control bits, so every request is off and nothing is folded.
// - An interrupt source reaches the interrupt output only while its enable bit is set.
//
// Added by the designer: the Avalon-MM interface to the registers.
`include "aesdrq_map.svh"

module aesdrq_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Avalon-MM register slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Raw requests from the accelerator core
    input wire logic [3:0] dma_src,
    input wire logic [3:0] irq_src,
    // Requests to the DMA controller
    output logic dma_req_ctx_in_ff,
    output logic dma_req_data_in_ff,
    output logic dma_req_data_out_ff,
    output logic dma_req_ctx_out_ff,
    // Interrupt line
    output logic irq_ff
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    aesdrq_pkg::aesdrq_regs_t cur_ff;
    aesdrq_pkg::aesdrq_regs_t nxt_cur;
    logic [31:0] cfg_word;
    logic [3:0] dma_en;
    logic [3:0] irq_en_eff;
    logic [3:0] dma_q;

    // Configuration register as read back, reserved bits zero
    always_comb begin
        cfg_word = `AESDRQ_CFG_RST;
        cfg_word[`AESDRQ_CFG_DIN_BIT] = cur_ff.din_en;
        cfg_word[`AESDRQ_CFG_DOUT_BIT] = cur_ff.dout_en;
        cfg_word[`AESDRQ_CFG_CIN_BIT] = cur_ff.cin_en;
        cfg_word[`AESDRQ_CFG_COUT_BIT] = cur_ff.cout_en;
        cfg_word[`AESDRQ_CFG_MAP_BIT] = cur_ff.map_cout;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective enables
    always_comb begin
        dma_en[`AESDRQ_SRC_DIN] = cur_ff.din_en;
        dma_en[`AESDRQ_SRC_DOUT] = cur_ff.dout_en;
        dma_en[`AESDRQ_SRC_CIN] = cur_ff.cin_en;
        dma_en[`AESDRQ_SRC_COUT] = cur_ff.map_cout ? cur_ff.dout_en : cur_ff.cout_en;
        irq_en_eff = cur_ff.irq_en;
        if (cur_ff.map_cout) begin
            irq_en_eff[`AESDRQ_SRC_COUT] = cur_ff.irq_en[`AESDRQ_SRC_DOUT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave and register writes
    always_comb begin
        nxt_cur = cur_ff;
        case (cur_ff.state)
            aesdrq_pkg::AESDRQ_ST_IDLE: begin
                if (read || write) begin
                    nxt_cur.state = aesdrq_pkg::AESDRQ_ST_ACK;
                    nxt_cur.waitrequest = 1'b0;
                    nxt_cur.readdata = `AESDRQ_RDATA_RST;
                    if (read) begin
                        if (address == `AESDRQ_CFG_OFS) begin
                            nxt_cur.readdata = cfg_word;
                        end else if (address == `AESDRQ_IRQST_OFS) begin
                            nxt_cur.readdata = {28'h0000000, irq_src};
                        end else if (address == `AESDRQ_IRQEN_OFS) begin
                            nxt_cur.readdata = {28'h0000000, cur_ff.irq_en};
                        end
                    end
                end
            end
            aesdrq_pkg::AESDRQ_ST_ACK: begin
                // Write lands at the edge where waitrequest is seen low
                nxt_cur.state = aesdrq_pkg::AESDRQ_ST_IDLE;
                nxt_cur.waitrequest = 1'b1;
                if (write) begin
                    if (address == `AESDRQ_CFG_OFS) begin
                        if (byteenable[0]) begin
                            nxt_cur.din_en = writedata[`AESDRQ_CFG_DIN_BIT];
                            nxt_cur.dout_en = writedata[`AESDRQ_CFG_DOUT_BIT];
                            nxt_cur.cin_en = writedata[`AESDRQ_CFG_CIN_BIT];
                        end
                        if (byteenable[1]) begin
                            nxt_cur.cout_en = writedata[`AESDRQ_CFG_COUT_BIT];
                            nxt_cur.map_cout = writedata[`AESDRQ_CFG_MAP_BIT];
                        end
                    end else if (address == `AESDRQ_IRQEN_OFS) begin
                        if (byteenable[0]) begin
                            nxt_cur.irq_en = writedata[3:0];
                        end
                    end
                end
            end
            default: begin
                nxt_cur.state = aesdrq_pkg::AESDRQ_ST_IDLE;
                nxt_cur.waitrequest = 1'b1;
            end
        endcase
    end

    // State register, all controls cleared at reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff.state <= aesdrq_pkg::AESDRQ_ST_IDLE;
            cur_ff.waitrequest <= 1'b1;
            cur_ff.readdata <= `AESDRQ_RDATA_RST;
            cur_ff.din_en <= 1'b0;
            cur_ff.dout_en <= 1'b0;
            cur_ff.cin_en <= 1'b0;
            cur_ff.cout_en <= 1'b0;
            cur_ff.map_cout <= 1'b0;
            cur_ff.irq_en <= `AESDRQ_IRQEN_RST;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign readdata = cur_ff.readdata;
    assign waitrequest = cur_ff.waitrequest;

    ////////////////////////////////////////////////////////////////////////////
    // Gating of DMA requests and interrupts
    aesdrq_gate #(
        .W(4)
    ) u_dma_gate (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .src(dma_src),
        .en(dma_en),
        .q_ff(dma_q),
        .any_ff()
    );

    aesdrq_gate #(
        .W(4)
    ) u_irq_gate (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .src(irq_src),
        .en(irq_en_eff),
        .q_ff(),
        .any_ff(irq_ff)
    );

    assign dma_req_ctx_in_ff = dma_q[`AESDRQ_SRC_CIN];
    assign dma_req_data_in_ff = dma_q[`AESDRQ_SRC_DIN];
    assign dma_req_data_out_ff = dma_q[`AESDRQ_SRC_DOUT];
    assign dma_req_ctx_out_ff = dma_q[`AESDRQ_SRC_COUT];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_cfg_write;
        write && !waitrequest && address == `AESDRQ_CFG_OFS && byteenable[0];
    endsequence

    sequence s_cfg_read;
        read && !waitrequest && address == `AESDRQ_CFG_OFS;
    endsequence

    a_din_write_gate: assert property (
        s_cfg_write ##0 writedata[`AESDRQ_CFG_DIN_BIT] == 1'b0 ##1 dma_src[1] |=> !dma_req_data_in_ff)
        else $error("data-in request passed while disabled");

    a_din_pass: assert property (
        cur_ff.din_en && dma_src[1] |=> dma_req_data_in_ff)
        else $error("data-in request not passed while enabled");

    a_dout_block: assert property (
        !cur_ff.dout_en |=> !dma_req_data_out_ff)
        else $error("data-out request passed while disabled");

    a_cin_gate: assert property (
        dma_req_ctx_in_ff |-> $past(cur_ff.cin_en) && $past(dma_src[0]))
        else $error("context-in request without enable");

    a_cout_gate: assert property (
        !cur_ff.map_cout && cur_ff.cout_en && dma_src[3] |=> dma_req_ctx_out_ff)
        else $error("context-out request not passed");

    a_fold_dma: assert property (
        cur_ff.map_cout && !cur_ff.dout_en |=> !dma_req_ctx_out_ff)
        else $error("folded context-out ignored data-out enable");

    a_fold_irq: assert property (
        cur_ff.map_cout && cur_ff.irq_en[2] && irq_src[3] |=> irq_ff)
        else $error("folded context-out interrupt lost");

    // Checked one edge on, once the asynchronous clear has settled
    a_cfg_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
        !resetn |=> cfg_word == `AESDRQ_CFG_RST && !dma_req_ctx_out_ff)
        else $error("controls not clear in reset");

    a_irq_mask: assert property (
        irq_en_eff == 4'h0 |=> !irq_ff)
        else $error("interrupt passed with all enables clear");

    a_reserved_zero: assert property (
        s_cfg_read |-> (readdata & ~`AESDRQ_CFG_MASK) == 32'h0000_0000)
        else $error("reserved config bits read nonzero");

endmodule
